// ### verilog/atc_trigger.sv
// acquisition trigger controller: arms, picks the trigger, places the window with a signed
// delay and keeps the captured window in a circular buffer readable over APB.
// assumes the output stage delivers angle and sample words on pclk; the relay level is a pin.
`timescale 1ns/10ps
`default_nettype none
module atc_trigger #(
	parameter int TICK_CYC = atc_pkg::RES_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] phase_a_angle,
	input wire logic angle_valid,
	input wire logic relay_closed,
	input wire logic [15:0] sample_data,
	output atc_pkg::atc_vstep_t vstep,
	output logic trigger_pulse,
	output logic results_ready,
	output logic acq_busy
);
	// ==========================================
	// state
	typedef struct packed {
		atc_pkg::atc_state_t state;
		atc_pkg::atc_ctrl_t ctrl;
		logic [11:0] angle_set;
		logic [15:0] delay_set;
		logic [15:0] volt_set;
		logic relay_s1;
		logic relay_s2;
		logic [13:0] tick_cnt;
		logic [3:0] samp_cnt;
		logic [11:0] prev_angle;
		logic prev_ok;
		logic [14:0] countdown;
		logic [13:0] hold_cnt;
		logic holding;
		logic [10:0] wp;
		logic [10:0] frz_wp;
		logic [10:0] rd_idx;
		logic [15:0] cap_count;
		logic [31:0] prdata;
		logic pslverr;
		logic trig;
		logic done;
		logic busy;
		atc_pkg::atc_vstep_t vstep;
	} atc_regs_t;

	atc_regs_t r_q;
	atc_regs_t r_d;
	logic [15:0] mem [atc_pkg::WIN_SAMPLES];

	logic setup_ph;
	logic wr_acc;
	logic tick;
	logic samp_tick;
	logic [3:0] depth_eff;
	logic [14:0] win_ticks;
	logic [15:0] neg_mag;
	logic [14:0] neg_ticks;
	logic [14:0] pos_ticks;
	logic [14:0] post_total;
	logic [11:0] target;
	logic [12:0] tsum;
	logic crossed;
	logic fire;
	logic start_cmd;
	logic abort_cmd;
	logic [11:0] rd_sum;
	logic [10:0] rd_addr;
	logic rec_en;

	// apb: zero wait states, read data latched in the setup cycle
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	// no wait states: every register answers from flops or the small buffer
	assign pready = 1'b1;
	assign prdata = r_q.prdata;
	assign pslverr = r_q.pslverr;
	assign vstep = r_q.vstep;
	assign trigger_pulse = r_q.trig;
	assign results_ready = r_q.done;
	assign acq_busy = r_q.busy;

	// delay base tick and sample divider
	// the tick counter runs free, so a trigger lands anywhere inside a tick and the
	// window is placed to within one tick
	assign tick = (r_q.tick_cnt == 14'(TICK_CYC - 1));
	// >= so that a depth change mid-run cannot strand the divider above its end
	assign samp_tick = tick & (r_q.samp_cnt >= depth_eff - 4'h1);

	// depth clamp keeps the window inside the 128 to 1280 ms span
	assign depth_eff = (r_q.ctrl.depth < atc_pkg::DEPTH_MIN) ? atc_pkg::DEPTH_MIN :
		(r_q.ctrl.depth > atc_pkg::DEPTH_MAX) ? atc_pkg::DEPTH_MAX : r_q.ctrl.depth;
	assign win_ticks = 15'(depth_eff * atc_pkg::WIN_UNIT_TICKS);

	assign pos_ticks = (r_q.delay_set > atc_pkg::POS_DELAY_MAX) ?
		15'(atc_pkg::POS_DELAY_MAX) : r_q.delay_set[14:0];
	// negative delay bounded by window depth
	assign neg_mag = 16'(-r_q.delay_set);
	assign neg_ticks = (neg_mag > {1'b0, win_ticks}) ? win_ticks : neg_mag[14:0];
	// post delay holds off the delay plus a full window past the trigger
	// pre delay leaves only the remainder after the trigger
	always_comb begin
		if (r_q.delay_set[15]) begin
			post_total = win_ticks - neg_ticks;
		end else begin
			post_total = 15'(pos_ticks + win_ticks);
		end
	end

	// reference to second or third phase adds 240 or 120 degrees
	always_comb begin
		unique case (r_q.ctrl.ref_phase)
			2'h1: tsum = {1'b0, r_q.angle_set} + {1'b0, atc_pkg::OFFS_B};
			2'h2: tsum = {1'b0, r_q.angle_set} + {1'b0, atc_pkg::OFFS_C};
			default: tsum = {1'b0, r_q.angle_set};
		endcase
		if (tsum >= {1'b0, atc_pkg::FULL_TURN}) begin
			target = 12'(tsum - {1'b0, atc_pkg::FULL_TURN});
		end else begin
			target = tsum[11:0];
		end
	end

	// a crossing seen before arming must not count, so prev_ok is cleared on arming
	// crossing of the target between two angle samples, wrap aware
	// a previous sample taken after arming is needed
	always_comb begin
		if (r_q.prev_angle <= phase_a_angle) begin
			crossed = (r_q.prev_angle < target) & (target <= phase_a_angle);
		end else begin
			crossed = (target > r_q.prev_angle) | (target <= phase_a_angle);
		end
		crossed = crossed & angle_valid & r_q.prev_ok;
	end

	// trigger decision while armed
	always_comb begin
		unique case (r_q.ctrl.source_select_setting)
			atc_pkg::SRC_INSTANT: fire = 1'b1;
			atc_pkg::SRC_ANGLE: fire = crossed;
			// relay already closed fires at once
			atc_pkg::SRC_VSTEP: fire = r_q.relay_s2;
			default: fire = 1'b0;
		endcase
	end

	assign start_cmd = wr_acc & (paddr[7:0] == atc_pkg::REG_CMD) & pstrb[0] &
		pwdata[atc_pkg::CMD_START];
	assign abort_cmd = wr_acc & (paddr[7:0] == atc_pkg::REG_CMD) & pstrb[0] &
		pwdata[atc_pkg::CMD_ABORT];

	// buffer readback starts at the oldest sample of the frozen window
	assign rd_sum = {1'b0, r_q.frz_wp} + {1'b0, r_q.rd_idx};
	assign rd_addr = (rd_sum >= 12'(atc_pkg::WIN_SAMPLES)) ?
		11'(rd_sum - 12'(atc_pkg::WIN_SAMPLES)) : rd_sum[10:0];
	// record continuously unless a result is being held
	assign rec_en = samp_tick & ~r_q.holding;

	// ==========================================
	// next state
	always_comb begin
		r_d = r_q;
		r_d.trig = 1'b0;
		r_d.done = 1'b0;
		r_d.vstep.load = 1'b0;
		// relay pin synchroniser
		// two flops: the relay contact is not timed to pclk
		r_d.relay_s1 = relay_closed;
		r_d.relay_s2 = r_q.relay_s1;
		r_d.tick_cnt = tick ? 14'h0000 : 14'(r_q.tick_cnt + 14'h0001);
		if (tick) begin
			r_d.samp_cnt = samp_tick ? 4'h0 : 4'(r_q.samp_cnt + 4'h1);
		end
		if (rec_en) begin
			r_d.wp = (r_q.wp == 11'(atc_pkg::WIN_SAMPLES - 1)) ? 11'h000 :
				11'(r_q.wp + 11'h001);
		end
		if (angle_valid) begin
			r_d.prev_angle = phase_a_angle;
			r_d.prev_ok = (r_q.state == atc_pkg::ST_ARMED);
		end

		// register writes
		if (wr_acc) begin
			unique case (paddr[7:0])
				atc_pkg::REG_CTRL: begin
					if (pstrb[0]) begin
						r_d.ctrl.rearm_mode = pwdata[atc_pkg::CTRL_REARM];
						r_d.ctrl.source_select_setting = pwdata[atc_pkg::CTRL_SRC_LSB +: 2];
						r_d.ctrl.ref_phase = pwdata[atc_pkg::CTRL_REF_LSB +: 2];
						r_d.ctrl.all_phases = pwdata[atc_pkg::CTRL_ALLPH];
						r_d.ctrl.phase_sel[0] = pwdata[atc_pkg::CTRL_PHSEL_LSB];
					end
					if (pstrb[1]) begin
						r_d.ctrl.phase_sel[1] = pwdata[atc_pkg::CTRL_PHSEL_LSB + 1];
						r_d.ctrl.depth = pwdata[atc_pkg::CTRL_DEPTH_LSB +: 4];
					end
				end
				atc_pkg::REG_ANGLE: begin
					if (pstrb[0]) r_d.angle_set[7:0] = pwdata[7:0];
					if (pstrb[1]) r_d.angle_set[11:8] = pwdata[11:8];
				end
				atc_pkg::REG_DELAY: begin
					if (pstrb[0]) r_d.delay_set[7:0] = pwdata[7:0];
					if (pstrb[1]) r_d.delay_set[15:8] = pwdata[15:8];
				end
				atc_pkg::REG_VOLT: begin
					if (pstrb[0]) r_d.volt_set[7:0] = pwdata[7:0];
					if (pstrb[1]) r_d.volt_set[15:8] = pwdata[15:8];
				end
				atc_pkg::REG_RDIDX: begin
					// an index past the window end reads the newest sample, it never wraps
					if (pstrb[0] & pstrb[1]) begin
						r_d.rd_idx = (pwdata[10:0] >= 11'(atc_pkg::WIN_SAMPLES)) ?
							11'(atc_pkg::WIN_SAMPLES - 1) : pwdata[10:0];
					end
				end
				default: begin
				end
			endcase
		end

		// sequencing
		unique case (r_q.state)
			atc_pkg::ST_IDLE: begin
				// a start arms an acquisition, or a run of them when rearm_mode is set
				if (start_cmd) begin
					r_d.state = atc_pkg::ST_ARMED;
					r_d.holding = 1'b0;
					r_d.prev_ok = 1'b0;
				end
			end
			atc_pkg::ST_ARMED: begin
				if (abort_cmd) begin
					r_d.state = atc_pkg::ST_IDLE;
				end else if (fire) begin
					r_d.state = atc_pkg::ST_POST;
					r_d.trig = 1'b1;
					r_d.countdown = post_total;
					// step and trigger in the same cycle
					if (r_q.ctrl.source_select_setting == atc_pkg::SRC_VSTEP) begin
						r_d.vstep.load = 1'b1;
						r_d.vstep.value = r_q.volt_set;
						if (r_q.ctrl.all_phases) begin
							r_d.vstep.phase_mask = 3'h7;
						end else begin
							r_d.vstep.phase_mask = 3'(3'h1 << r_q.ctrl.phase_sel);
						end
					end
				end
			end
			atc_pkg::ST_POST: begin
				if (abort_cmd) begin
					r_d.state = atc_pkg::ST_IDLE;
				end else if (r_q.countdown == 15'h0000) begin
					// freeze once the post part is stored
					r_d.holding = 1'b1;
					// the slot written next holds the oldest sample of the window
					r_d.frz_wp = r_d.wp;
					r_d.done = 1'b1;
					r_d.cap_count = 16'(r_q.cap_count + 16'h0001);
					r_d.hold_cnt = atc_pkg::REFRESH_TICKS;
					// re-arming goes to hold, then arms again
					r_d.state = r_q.ctrl.rearm_mode ? atc_pkg::ST_HOLD : atc_pkg::ST_IDLE;
				end else if (tick) begin
					r_d.countdown = 15'(r_q.countdown - 15'h0001);
				end
			end
			atc_pkg::ST_HOLD: begin
				// clearing the re-arm bit during the hold also ends the run
				if (abort_cmd | ~r_q.ctrl.rearm_mode) begin
					r_d.state = atc_pkg::ST_IDLE;
				end else if (r_q.hold_cnt == 14'h0000) begin
					// results stay up about one second
					r_d.state = atc_pkg::ST_ARMED;
					r_d.holding = 1'b0;
					r_d.prev_ok = 1'b0;
				end else if (tick) begin
					r_d.hold_cnt = 14'(r_q.hold_cnt - 14'h0001);
				end
			end
		endcase
		// busy comes from a flop so the pin carries no decode glitches
		r_d.busy = (r_d.state == atc_pkg::ST_ARMED) | (r_d.state == atc_pkg::ST_POST);

		// read data and error answer, latched in the setup cycle
		if (setup_ph) begin
			r_d.pslverr = 1'b0;
			unique case (paddr[7:0])
				atc_pkg::REG_CTRL: r_d.prdata = {20'h00000, r_q.ctrl.depth,
					r_q.ctrl.phase_sel, r_q.ctrl.all_phases, r_q.ctrl.ref_phase,
					r_q.ctrl.source_select_setting, r_q.ctrl.rearm_mode};
				atc_pkg::REG_CMD: r_d.prdata = 32'h00000000;
				atc_pkg::REG_ANGLE: r_d.prdata = {20'h00000, r_q.angle_set};
				atc_pkg::REG_DELAY: r_d.prdata = {16'h0000, r_q.delay_set};
				atc_pkg::REG_VOLT: r_d.prdata = {16'h0000, r_q.volt_set};
				atc_pkg::REG_STATUS: r_d.prdata = {r_q.cap_count, 9'h000,
					r_q.relay_s2, r_q.holding, 1'b0, r_q.state};
				atc_pkg::REG_RDIDX: r_d.prdata = {21'h000000, r_q.rd_idx};
				atc_pkg::REG_RDDATA: r_d.prdata = {16'h0000, mem[rd_addr]};
				default: begin
					r_d.prdata = 32'h00000000;
					r_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '{state: atc_pkg::ST_IDLE,
				ctrl: '{rearm_mode: 1'b0, source_select_setting: atc_pkg::SRC_INSTANT,
					ref_phase: 2'h0, all_phases: 1'b0, phase_sel: 2'h0,
					depth: atc_pkg::DEPTH_RST},
				angle_set: atc_pkg::ANGLE_RST,
				delay_set: atc_pkg::DELAY_RST,
				volt_set: atc_pkg::VOLT_RST,
				vstep: '{load: 1'b0, phase_mask: 3'h0, value: 16'h0000},
				default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// sample storage has no reset; content is only valid once frozen
	// limitation: a held result stops recording, so a start that follows a held
	// result finds its pre-start slots still filled from the older window
	always_ff @(posedge pclk) begin
		if (rec_en) begin
			mem[r_q.wp] <= sample_data;
		end
	end
endmodule
`default_nettype wire

// ### verilog/atc_pkg.sv
// package of the acquisition trigger controller: register map, field layout, reset values,
// state codes and timing figures.
// assumes a 100 MHz pclk and APB with 32-bit data, one aligned word per register.
package atc_pkg;
	// ==========================================
	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int DELAY_RES_NS = 100000; // 0.1 ms delay resolution
	localparam int RES_CYC = (DELAY_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POS_DELAY_MAX_MS = 1000;
	localparam logic [15:0] POS_DELAY_MAX = 16'(POS_DELAY_MAX_MS * 10); // in 0.1 ms steps
	localparam int WIN_UNIT_MS = 128; // window depth grows in 128 ms steps
	localparam logic [3:0] DEPTH_MIN = 4'h1; // 128 ms
	localparam logic [3:0] DEPTH_MAX = 4'hA; // 1280 ms
	localparam int WIN_SAMPLES = WIN_UNIT_MS * 10; // samples in one window
	localparam logic [14:0] WIN_UNIT_TICKS = 15'(WIN_SAMPLES);
	localparam int REFRESH_MS = 1000; // re-arm hold for about one display refresh
	localparam logic [13:0] REFRESH_TICKS = 14'(REFRESH_MS * 10);
	// ==========================================
	// angles in tenths of a degree
	localparam logic [11:0] FULL_TURN = 12'hE10; // 360.0
	localparam logic [11:0] OFFS_B = 12'h960; // 240.0
	localparam logic [11:0] OFFS_C = 12'h4B0; // 120.0
	// ==========================================
	// register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_ANGLE = 8'h08;
	localparam logic [7:0] REG_DELAY = 8'h0C;
	localparam logic [7:0] REG_VOLT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_RDIDX = 8'h18;
	localparam logic [7:0] REG_RDDATA = 8'h1C;
	// ==========================================
	// field positions
	localparam int CTRL_REARM = 0;
	localparam int CTRL_SRC_LSB = 1; // two bits
	localparam int CTRL_REF_LSB = 3; // two bits, trigger phase reference
	localparam int CTRL_ALLPH = 5;
	localparam int CTRL_PHSEL_LSB = 6; // two bits
	localparam int CTRL_DEPTH_LSB = 8; // four bits
	localparam int CMD_START = 0;
	localparam int CMD_ABORT = 1;
	// ==========================================
	// source codes and reset values
	localparam logic [1:0] SRC_INSTANT = 2'h0;
	localparam logic [1:0] SRC_ANGLE = 2'h1;
	localparam logic [1:0] SRC_VSTEP = 2'h2;
	localparam logic [3:0] DEPTH_RST = 4'h1;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic [11:0] ANGLE_RST = 12'h000;
	localparam logic [15:0] VOLT_RST = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARMED = 4'h2,
		ST_POST = 4'h4,
		ST_HOLD = 4'h8
	} atc_state_t;

	typedef struct packed {
		logic rearm_mode;
		logic [1:0] source_select_setting;
		logic [1:0] ref_phase;
		logic all_phases;
		logic [1:0] phase_sel;
		logic [3:0] depth;
	} atc_ctrl_t;

	// voltage step request towards the output stage
	typedef struct packed {
		logic load;
		logic [2:0] phase_mask;
		logic [15:0] value;
	} atc_vstep_t;
endpackage

// ### tb/atc_stage_model.sv
// output stage model: phase one angle, relay level and sample words.
// assumes pclk and presetn of the bench; relay follows relay_req one cycle later.
`timescale 1ns/10ps
`default_nettype none
module atc_stage_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic relay_req,
	output logic [11:0] phase_a_angle,
	output logic angle_valid,
	output logic relay_closed,
	output logic [15:0] sample_data
);
	logic [2:0] div_q;
	// ==========================================
	// angle steps 6.0 deg every 8 cycles; samples count cycles so gaps show spacing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 3'h0;
			phase_a_angle <= 12'h000;
			angle_valid <= 1'b0;
			relay_closed <= 1'b0;
			sample_data <= 16'h0000;
		end else begin
			div_q <= div_q + 3'h1;
			angle_valid <= (div_q == 3'h7);
			if (div_q == 3'h7) begin
				phase_a_angle <= (phase_a_angle >= 12'hDD4) ? 12'h000 : phase_a_angle + 12'h03C;
			end
			relay_closed <= relay_req;
			sample_data <= sample_data + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ### tb/atc_trigger_sva.sv
// checker for the acquisition trigger controller, bound to its ports.
// assumes full-word APB writes to control; control and step value are shadowed here.
`timescale 1ns/10ps
`default_nettype none
module atc_trigger_sva #(
	parameter int TICK_CYC = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] phase_a_angle,
	input wire logic angle_valid,
	input wire logic relay_closed,
	input wire logic [15:0] sample_data,
	input wire atc_pkg::atc_vstep_t vstep,
	input wire logic trigger_pulse,
	input wire logic results_ready,
	input wire logic acq_busy
);
	localparam int LO = 9999 * TICK_CYC;
	localparam int HI = 10003 * TICK_CYC + 8;
	logic wr, go, ab, hold_q, run_q;
	logic [11:0] ctrl_q;
	logic [15:0] volt_q;
	logic [19:0] cnt_q;
	assign wr = psel && penable && pwrite && pready;
	assign go = wr && paddr[7:0] == atc_pkg::REG_CMD && pwdata[0] && !acq_busy && !hold_q;
	assign ab = wr && paddr[7:0] == atc_pkg::REG_CMD && pwdata[1];
	// ==========================================
	// shadow settings; hold_q marks a possible refresh hold, where start is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 12'h100;
			volt_q <= 16'h0000;
			hold_q <= 1'b0;
			run_q <= 1'b0;
			cnt_q <= 20'h00000;
		end else begin
			if (wr && paddr[7:0] == atc_pkg::REG_CTRL) ctrl_q <= pwdata[11:0];
			if (wr && paddr[7:0] == atc_pkg::REG_VOLT) begin
				if (pstrb[0]) volt_q[7:0] <= pwdata[7:0];
				if (pstrb[1]) volt_q[15:8] <= pwdata[15:8];
			end
			if (trigger_pulse && ctrl_q[0]) hold_q <= 1'b1;
			else if (ab) hold_q <= 1'b0;
			if (results_ready && ctrl_q[0]) run_q <= 1'b1;
			else if (trigger_pulse || ab) run_q <= 1'b0;
			cnt_q <= run_q ? cnt_q + 20'h00001 : 20'h00000;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_start_arms: assert property (go && ctrl_q[2:1] != 2'h3 |=> acq_busy)
		else $error("start did not arm");
	a_oneshot_idle: assert property (results_ready && !ctrl_q[0] |=>
		(!acq_busy && !trigger_pulse)[*2])
		else $error("one-shot did not stay idle");
	a_refresh_hold: assert property (trigger_pulse && run_q |-> cnt_q >= LO)
		else $error("re-arm came too early");
	a_rearm_auto: assert property (run_q && ctrl_q[2:1] == 2'h0 |-> cnt_q <= HI)
		else $error("re-arm did not trigger");
	a_instant_fire: assert property (go && ctrl_q[2:1] == 2'h0 |-> ##2 trigger_pulse)
		else $error("instant trigger missing");
	a_step_load: assert property (trigger_pulse |-> vstep.load == (ctrl_q[2:1] == 2'h2))
		else $error("step load not with trigger");
	a_step_fields: assert property (vstep.load |-> vstep.value == volt_q &&
		vstep.phase_mask == (ctrl_q[5] ? 3'h7 : 3'h1 << ctrl_q[7:6]))
		else $error("step value or mask wrong");
	a_relay_gate: assert property (trigger_pulse && ctrl_q[2:1] == 2'h2 |->
		$past(relay_closed, 3))
		else $error("step fired with relay open");
	a_relay_now: assert property (go && ctrl_q[2:1] == 2'h2 && relay_closed &&
		$past(relay_closed, 2) |-> ##[1:6] trigger_pulse)
		else $error("closed relay step did not fire");
	a_unmapped_err: assert property (psel && penable |->
		pslverr == (paddr[7:0] > 8'h1C || paddr[1:0] != 2'h0))
		else $error("slave error flag wrong");
	c_instant: cover property (go && ctrl_q[2:1] == 2'h0);
	c_step: cover property (vstep.load);
	c_rearm: cover property (trigger_pulse && run_q);
	c_err: cover property (pslverr);
endmodule
bind atc_trigger atc_trigger_sva #(.TICK_CYC(TICK_CYC)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.phase_a_angle(phase_a_angle), .angle_valid(angle_valid), .relay_closed(relay_closed),
	.sample_data(sample_data), .vstep(vstep), .trigger_pulse(trigger_pulse),
	.results_ready(results_ready), .acq_busy(acq_busy));
`default_nettype wire

// ### tb/test_atc_trigger.sv
// self-checking bench for the acquisition trigger controller.
// assumes a short tick (4 cycles) and the output stage model on the far side.
`timescale 1ns/10ps
`default_nettype none
module test_atc_trigger;
	localparam int T = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, relay_req = 1'b0, err;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, angle_valid, relay_closed, trigger_pulse, results_ready, acq_busy;
	logic [11:0] phase_a_angle, ang_prev, ang_cur;
	logic [15:0] sample_data, s_start, s_trig, old, v;
	atc_pkg::atc_vstep_t vstep;
	int failures = 0, num_checks = 0, n, e, tg, ph, al;
	always #5 pclk = ~pclk;
	atc_trigger #(.TICK_CYC(T)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_angle(phase_a_angle),
		.angle_valid(angle_valid), .relay_closed(relay_closed), .sample_data(sample_data),
		.vstep(vstep), .trigger_pulse(trigger_pulse), .results_ready(results_ready),
		.acq_busy(acq_busy));
	atc_stage_model u_stage (.pclk(pclk), .presetn(presetn), .relay_req(relay_req),
		.phase_a_angle(phase_a_angle), .angle_valid(angle_valid), .relay_closed(relay_closed),
		.sample_data(sample_data));
	// keep the last two qualified angles to judge the crossing
	always @(posedge pclk) begin
		if (angle_valid) begin
			ang_prev <= ang_cur;
			ang_cur <= phase_a_angle;
		end
	end
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		// a transfer that has just ended still shows psel; let one edge pass first
		if (psel === 1'b1) @(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			failures++;
			$display("ERROR %0t: bus answer timed out", $time);
			finish_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// bounded wait for trigger (0) or frozen window (1); n is the cycle count
	task automatic wait_ev(input logic which, input int bound);
		n = 0;
		while (n < bound) begin
			@(posedge pclk);
			n++;
			if ((which ? results_ready : trigger_pulse) === 1'b1) begin
				if (!which) s_trig = sample_data;
				return;
			end
		end
		failures++;
		$display("ERROR %0t: wait timed out", $time);
		finish_test();
	endtask
	function automatic int exp_post(input logic [15:0] dl);
		int m;
		m = int'($signed(dl));
		if (m >= 0) return (m > 10000 ? 10000 : m) + 1280;
		return 1280 - (-m > 1280 ? 1280 : -m);
	endfunction
	function automatic logic crossed(input int p, input int c, input int t);
		if (c >= p) return p < t && t <= c;
		return t > p || t <= c;
	endfunction
	// one-shot instant capture, then window timing and contents
	task automatic oneshot(input logic [15:0] dl);
		apb(1'b1, atc_pkg::REG_DELAY, {16'h0, dl});
		apb(1'b0, atc_pkg::REG_DELAY, 32'h0);
		chk(rd[15:0], dl);
		s_start = sample_data;
		apb(1'b1, atc_pkg::REG_CMD, 32'h1);
		wait_ev(1'b0, 8);
		chk(n, 2);
		e = exp_post(dl);
		wait_ev(1'b1, (e + 4) * T);
		chk(n >= (e - 1) * T && n <= (e + 2) * T, 1);
		apb(1'b0, atc_pkg::REG_STATUS, 32'h0);
		chk(rd[3:0], 4'h1);
		apb(1'b1, atc_pkg::REG_RDIDX, 32'h0);
		apb(1'b0, atc_pkg::REG_RDDATA, 32'h0);
		old = rd[15:0];
		apb(1'b1, atc_pkg::REG_RDIDX, 32'h1);
		apb(1'b0, atc_pkg::REG_RDDATA, 32'h0);
		chk(16'(rd[15:0] - old), 16'h0004);
		if (dl[15]) chk($signed(old - s_start) < 0, 1);
		else chk($signed(old - s_trig) > 0, 1);
	endtask
	initial begin
		void'($urandom(32'h93a9));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, atc_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h100);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		// only the strobed low lane of a partial write may land
		pstrb <= 4'h1;
		apb(1'b1, atc_pkg::REG_VOLT, 32'h12AB);
		pstrb <= 4'hF;
		apb(1'b0, atc_pkg::REG_VOLT, 32'h0);
		chk(rd, 32'h000000AB);
		for (int i = 0; i < 3; i++) begin
			v = 16'($urandom);
			apb(1'b1, atc_pkg::REG_VOLT, {16'h0, v});
			apb(1'b0, atc_pkg::REG_VOLT, 32'h0);
			chk(rd[15:0], v);
		end
		oneshot(16'($urandom_range(2, 20)));
		oneshot(16'hFF9C);
		// angle source for each phase reference, aborted after the trigger
		for (int r = 0; r < 3; r++) begin
			tg = (r == 0) ? 0 : $urandom_range(0, 3599);
			apb(1'b1, atc_pkg::REG_CTRL, 32'h102 | (r << 3));
			apb(1'b1, atc_pkg::REG_ANGLE, tg);
			apb(1'b1, atc_pkg::REG_CMD, 32'h1);
			wait_ev(1'b0, 1200);
			chk(crossed(ang_prev, ang_cur, (tg + (3 - r) % 3 * 1200) % 3600), 1);
			apb(1'b1, atc_pkg::REG_CMD, 32'h2);
			apb(1'b0, atc_pkg::REG_STATUS, 32'h0);
			chk(rd[3:0], 4'h1);
		end
		// voltage step: relay open waits, relay closed fires at once
		ph = $urandom_range(0, 2);
		al = $urandom_range(0, 1);
		apb(1'b1, atc_pkg::REG_CTRL, 32'h104 | (al << 5) | (ph << 6));
		apb(1'b1, atc_pkg::REG_CMD, 32'h1);
		repeat (20) @(posedge pclk);
		apb(1'b0, atc_pkg::REG_STATUS, 32'h0);
		chk(rd[3:0], 4'h2);
		relay_req <= 1'b1;
		wait_ev(1'b0, 20);
		chk(vstep, {1'b1, al ? 3'h7 : 3'h1 << ph, v});
		apb(1'b1, atc_pkg::REG_CMD, 32'h2);
		apb(1'b1, atc_pkg::REG_CMD, 32'h1);
		wait_ev(1'b0, 8);
		chk(n, 2);
		apb(1'b1, atc_pkg::REG_CMD, 32'h2);
		relay_req <= 1'b0;
		// re-arming with a short window: two captures from one start
		apb(1'b1, atc_pkg::REG_CTRL, 32'h101);
		apb(1'b1, atc_pkg::REG_DELAY, 32'hFB0A);
		apb(1'b1, atc_pkg::REG_CMD, 32'h1);
		wait_ev(1'b0, 8);
		wait_ev(1'b1, 20 * T);
		wait_ev(1'b0, 10010 * T);
		chk(n >= 9999 * T, 1);
		wait_ev(1'b1, 20 * T);
		apb(1'b1, atc_pkg::REG_CMD, 32'h2);
		apb(1'b0, atc_pkg::REG_STATUS, 32'h0);
		chk(rd[3:0], 4'h1);
		finish_test();
	end
endmodule
`default_nettype wire
